// File: cpu_regfile_defs.vh
`ifndef CPU_REGFILE_DEFS_VH
`define CPU_REGFILE_DEFS_VH

`define GPR_RESET        32'h0000_0000
`define SP_INDEX         3'h7
`define SIZE_BYTE        2'h0
`define SIZE_WORD        2'h1
`define SIZE_LONG        2'h2

`define CTL_OP_LOAD      3'h0
`define CTL_OP_AND       3'h1
`define CTL_OP_OR        3'h2
`define CTL_OP_XOR       3'h3
`define CTL_OP_STORE     3'h4

`define ECB_TRACE_BIT    7
`define ECB_RSVD_VALUE   4'hF
`define ECB_MASK_MSB     2
`define ECB_MASK_LSB     0
`define ECB_RESET_TRACE  1'b0
`define ECB_RESET_MASK   3'h7
`define FLAG_RESET       8'h80
`define MAC_RESET        64'h0000_0000_0000_0000

`define INTR_BLOCK_STATES 2'h3
`define ICM_MODE0        2'h0

`define PC_RESET         24'h00_0000
`define PC_STEP          24'h00_0002
`define RSVD_BYTE        8'h00
`define VEC_BASE         24'h00_0000
`define VEC_PAD          14'h0000
`define SLOT_ALIGN       2'h0
`define MI_PAD           16'h0000

`define PUSH_LONG_STEP   32'h0000_0004
`define PUSH_WORD_STEP   32'h0000_0002
`define WORD_PAD         16'h0000

`endif

// File: cpu_register_file_adv_mode.v
`timescale 1ns/1ps
`include "cpu_regfile_defs.vh"

module cpu_register_file_adv_mode #(
	parameter GPR_COUNT = 8
) (
	input  wire        clk,
	input  wire        reset,
	// General register write port
	input  wire        gpr_wr_en,
	input  wire [2:0]  gpr_wr_idx,
	input  wire [1:0]  gpr_wr_size,
	input  wire        gpr_wr_upper,
	input  wire        gpr_wr_byte_hi,
	input  wire [31:0] gpr_wr_data,
	// General register read port, one cycle latency
	input  wire [2:0]  gpr_rd_idx,
	input  wire [1:0]  gpr_rd_size,
	input  wire        gpr_rd_upper,
	input  wire        gpr_rd_byte_hi,
	output reg  [31:0] gpr_rd_data_reg,
	// Register used as address pointer
	input  wire [2:0]  addr_idx,
	output reg  [23:0] eff_addr_reg,
	output wire [31:0] stack_pointer_gpr,
	// Program counter
	input  wire        pc_step,
	input  wire        pc_load_en,
	input  wire [23:0] pc_load_data,
	output wire [23:0] fetch_addr,
	// Exception vector fetch
	input  wire [7:0]  vec_num,
	output reg  [23:0] vec_addr_reg,
	input  wire        vec_load_en,
	input  wire [31:0] vec_rdata,
	// Memory-indirect branch
	input  wire [7:0]  mi_field,
	output reg  [23:0] mi_addr_reg,
	input  wire        mi_load_en,
	input  wire [31:0] mi_rdata,
	output reg  [31:0] mi_target_reg,
	// Control and flag byte operations
	input  wire        ctl_op_en,
	input  wire        ctl_sel_ext,
	input  wire [2:0]  ctl_op,
	input  wire [7:0]  ctl_op_data,
	output reg  [7:0]  ctl_rd_data_reg,
	input  wire        flag_wr_en,
	input  wire [7:0]  flag_wr_data,
	output wire [7:0]  extension_control_byte,
	output wire [7:0]  cond_flag_byte,
	output wire [2:0]  intr_mask_level,
	output reg         intr_blocked_reg,
	// Trace
	input  wire        instr_done,
	output reg         trace_req_reg,
	// Multiply-accumulate register
	input  wire        mac_clear,
	input  wire        mac_acc_en,
	input  wire [31:0] mac_product,
	input  wire        mac_wr_hi,
	input  wire        mac_wr_lo,
	input  wire [31:0] mac_wr_data,
	output wire [63:0] multiply_accum_reg,
	// Exception and call stack frames
	input  wire        exc_start,
	input  wire        call_start,
	input  wire [1:0]  intr_ctrl_mode,
	output wire        push_busy,
	output wire        push_valid,
	output wire        push_long,
	output wire [23:0] push_addr,
	output wire [31:0] push_data
);

	wire [31:0] gpr_mem [0:GPR_COUNT-1];
	reg  [23:0] pc_reg;
	reg         trace_bit_reg;
	reg  [2:0]  mask_reg;
	reg  [7:0]  flag_reg;
	reg  [63:0] mac_reg;
	reg  [1:0]  block_cnt_reg;
	reg  [3:0]  wr_lane;
	reg  [31:0] wr_aligned;
	reg  [31:0] rd_sel;
	reg  [7:0]  ctl_cur;
	reg  [7:0]  ctl_new;
	wire        sp_wr_en;
	wire [31:0] sp_wr_data;
	wire [31:0] rd_word;

	// Reserved bits are not stored, so they cannot drift from one
	assign extension_control_byte = {trace_bit_reg, `ECB_RSVD_VALUE,
		mask_reg};
	assign cond_flag_byte     = flag_reg;
	assign intr_mask_level    = mask_reg;
	assign multiply_accum_reg = mac_reg;
	assign stack_pointer_gpr  = gpr_mem[`SP_INDEX];
	assign fetch_addr         = {pc_reg[23:1], 1'b0};

	// Lane enables: [3] upper half, [2] lower half, [1] high byte, [0] low
	always @*
	begin
		wr_lane    = 4'h0;
		wr_aligned = gpr_wr_data;
		case (gpr_wr_size)
		`SIZE_LONG:
			wr_lane = 4'hF;
		`SIZE_WORD:
		begin
			if (gpr_wr_upper)
			begin
				wr_lane    = 4'h8;
				wr_aligned = {gpr_wr_data[15:0], gpr_wr_data[15:0]};
			end
			else
				wr_lane = 4'h6;
		end
		`SIZE_BYTE:
		begin
			wr_aligned = {4{gpr_wr_data[7:0]}};
			if (gpr_wr_byte_hi)
				wr_lane = 4'h2;
			else
				wr_lane = 4'h1;
		end
		default:
			wr_lane = 4'h0;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < GPR_COUNT; gi = gi + 1)
		begin : gpr_slot
			reg [31:0] word_reg;

			// One driver per slot; the array is only a read view
			assign gpr_mem[gi] = word_reg;

			always @(posedge clk or posedge reset)
			begin
				if (reset)
					word_reg <= `GPR_RESET;
				else if (gi == `SP_INDEX && sp_wr_en)
					word_reg <= sp_wr_data;
				else if (gpr_wr_en && gpr_wr_idx == gi)
				begin
					// Each view writes only its own lanes
					if (wr_lane[3])
						word_reg[31:16] <= wr_aligned[31:16];
					if (wr_lane[2] | wr_lane[1])
						word_reg[15:8] <= wr_aligned[15:8];
					if (wr_lane[2] | wr_lane[0])
						word_reg[7:0] <= wr_aligned[7:0];
				end
			end
		end
	endgenerate

	assign rd_word = gpr_mem[gpr_rd_idx];

	// Narrow reads are zero extended; sign handling is the ALU's job
	always @*
	begin
		rd_sel = rd_word;
		case (gpr_rd_size)
		`SIZE_LONG:
			rd_sel = rd_word;
		`SIZE_WORD:
			if (gpr_rd_upper)
				rd_sel = {16'h0000, rd_word[31:16]};
			else
				rd_sel = {16'h0000, rd_word[15:0]};
		`SIZE_BYTE:
			if (gpr_rd_byte_hi)
				rd_sel = {24'h00_0000, rd_word[15:8]};
			else
				rd_sel = {24'h00_0000, rd_word[7:0]};
		default:
			rd_sel = rd_word;
		endcase
	end

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			gpr_rd_data_reg <= `GPR_RESET;
			eff_addr_reg    <= `PC_RESET;
		end
		else
		begin
			gpr_rd_data_reg <= rd_sel;
			// Only 24 address bits leave the core
			eff_addr_reg <= gpr_mem[addr_idx][23:0];
		end
	end

	// Program counter: indirect and vector loads outrank plain loads
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			pc_reg <= `PC_RESET;
		else if (vec_load_en)
			pc_reg <= vec_rdata[23:0];
		else if (mi_load_en)
			pc_reg <= mi_rdata[23:0];
		else if (pc_load_en)
			pc_reg <= pc_load_data;
		else if (pc_step)
			pc_reg <= pc_reg + `PC_STEP;
	end

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			vec_addr_reg  <= `VEC_BASE;
			mi_addr_reg   <= `VEC_BASE;
			mi_target_reg <= `GPR_RESET;
		end
		else
		begin
			vec_addr_reg <= `VEC_BASE + {`VEC_PAD, vec_num,
				`SLOT_ALIGN};
			// Eight-bit field cannot reach past the lowest 256 bytes
			mi_addr_reg <= {`MI_PAD, mi_field};
			if (mi_load_en)
				mi_target_reg <= {`RSVD_BYTE, mi_rdata[23:0]};
		end
	end

	// Control byte operations
	always @*
	begin
		if (ctl_sel_ext)
			ctl_cur = extension_control_byte;
		else
			ctl_cur = flag_reg;
		case (ctl_op)
		`CTL_OP_LOAD:
			ctl_new = ctl_op_data;
		`CTL_OP_AND:
			ctl_new = ctl_cur & ctl_op_data;
		`CTL_OP_OR:
			ctl_new = ctl_cur | ctl_op_data;
		`CTL_OP_XOR:
			ctl_new = ctl_cur ^ ctl_op_data;
		default:
			ctl_new = ctl_cur;
		endcase
	end

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			trace_bit_reg   <= `ECB_RESET_TRACE;
			mask_reg        <= `ECB_RESET_MASK;
			flag_reg        <= `FLAG_RESET;
			ctl_rd_data_reg <= `FLAG_RESET;
		end
		else
		begin
			if (ctl_op_en && ctl_op == `CTL_OP_STORE)
				ctl_rd_data_reg <= ctl_cur;
			if (ctl_op_en && ctl_sel_ext && ctl_op != `CTL_OP_STORE)
			begin
				trace_bit_reg <= ctl_new[`ECB_TRACE_BIT];
				mask_reg <= ctl_new[`ECB_MASK_MSB:`ECB_MASK_LSB];
			end
			if (ctl_op_en && !ctl_sel_ext && ctl_op != `CTL_OP_STORE)
				flag_reg <= ctl_new;
			else if (flag_wr_en)
				flag_reg <= flag_wr_data;
		end
	end

	// Interrupt hold-off after a control byte update
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			block_cnt_reg    <= 2'h0;
			intr_blocked_reg <= 1'b0;
		end
		else if (ctl_op_en && ctl_sel_ext && ctl_op != `CTL_OP_STORE)
		begin
			block_cnt_reg    <= `INTR_BLOCK_STATES - 2'h1;
			intr_blocked_reg <= 1'b1;
		end
		else if (block_cnt_reg != 2'h0)
			block_cnt_reg <= block_cnt_reg - 2'h1;
		else
			intr_blocked_reg <= 1'b0;
	end

	// Trace request follows each completed instruction while the trace bit is set
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			trace_req_reg <= 1'b0;
		else
			trace_req_reg <= instr_done & trace_bit_reg;
	end

	// Accumulator: clear wins, then accumulate, then halves
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			mac_reg <= `MAC_RESET;
		else if (mac_clear)
			mac_reg <= `MAC_RESET;
		else if (mac_acc_en)
			mac_reg <= mac_reg + {{32{mac_product[31]}}, mac_product};
		else
		begin
			if (mac_wr_hi)
				mac_reg[63:32] <= mac_wr_data;
			if (mac_wr_lo)
				mac_reg[31:0] <= mac_wr_data;
		end
	end

	stack_frame_push u_push (
		.clk                    (clk),
		.reset                  (reset),
		.exc_start              (exc_start),
		.call_start             (call_start),
		.intr_ctrl_mode         (intr_ctrl_mode),
		.pc                     (pc_reg),
		.cond_flag_byte         (flag_reg),
		.extension_control_byte (extension_control_byte),
		.sp                     (gpr_mem[`SP_INDEX]),
		.busy                   (push_busy),
		.push_valid_reg         (push_valid),
		.push_long_reg          (push_long),
		.push_addr_reg          (push_addr),
		.push_data_reg          (push_data),
		.sp_wr_en_reg           (sp_wr_en),
		.sp_wr_data_reg         (sp_wr_data)
	);

endmodule // cpu_register_file_adv_mode

// File: cpu_register_file_adv_mode_tb.sv
`timescale 1ns/1ps
module cpu_register_file_adv_mode_tb;
	reg         clk, reset, obs_en, gpr_wr_upper, gpr_wr_byte_hi;
	reg         gpr_rd_upper, gpr_rd_byte_hi, ctl_sel_ext;
	reg  [11:0] stb;
	reg  [2:0]  gpr_wr_idx, gpr_rd_idx, addr_idx, ctl_op;
	reg  [1:0]  gpr_wr_size, gpr_rd_size, intr_ctrl_mode;
	reg  [31:0] gpr_wr_data, vec_rdata, mi_rdata, mac_wr_data, gv [0:7];
	reg  [23:0] pc_load_data;
	reg  [7:0]  vec_num, mi_field, ctl_op_data, flag_wr_data;
	reg  [15:0] r;
	reg  [67:0] n;
	wire [31:0] gpr_rd_data_reg, stack_pointer_gpr, mi_target_reg, push_data;
	wire [23:0] eff_addr_reg, fetch_addr, vec_addr_reg, mi_addr_reg, push_addr;
	wire [7:0]  ctl_rd_data_reg, extension_control_byte, cond_flag_byte;
	wire        intr_blocked_reg, trace_req_reg, push_busy, push_valid;
	wire        push_long;
	wire [63:0] multiply_accum_reg;
	logic [67:0] q [$];
	logic [56:0] pq [$];
	int error_cnt = 0;
	int checks_done = 0;
	int i;

	cpu_register_file_adv_mode u_cpu_register_file_adv_mode (
		.clk, .reset, .gpr_wr_en(stb[10]), .gpr_wr_idx, .gpr_wr_size,
		.gpr_wr_upper, .gpr_wr_byte_hi, .gpr_wr_data, .gpr_rd_idx,
		.gpr_rd_size, .gpr_rd_upper, .gpr_rd_byte_hi, .gpr_rd_data_reg,
		.addr_idx, .eff_addr_reg, .stack_pointer_gpr, .pc_step(stb[0]),
		.pc_load_en(stb[1]), .pc_load_data, .fetch_addr, .vec_num,
		.vec_addr_reg, .vec_load_en(stb[2]), .vec_rdata, .mi_field,
		.mi_addr_reg, .mi_load_en(stb[3]), .mi_rdata, .mi_target_reg,
		.ctl_op_en(stb[11]), .ctl_sel_ext, .ctl_op, .ctl_op_data,
		.ctl_rd_data_reg, .flag_wr_en(stb[7]), .flag_wr_data,
		.extension_control_byte, .cond_flag_byte, .intr_mask_level(),
		.intr_blocked_reg, .instr_done(stb[4]), .trace_req_reg,
		.mac_clear(1'b0), .mac_acc_en(1'b0), .mac_product(32'h0000_0000),
		.mac_wr_hi(stb[8]), .mac_wr_lo(stb[9]), .mac_wr_data,
		.multiply_accum_reg, .exc_start(stb[5]), .call_start(stb[6]),
		.intr_ctrl_mode, .push_busy, .push_valid, .push_long, .push_addr,
		.push_data);

	function automatic [15:0] lfsr(input [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	function automatic [63:0] pick(input [3:0] s);
		case (s)
			4'h0: pick = 64'(gpr_rd_data_reg);
			4'h1: pick = 64'(extension_control_byte);
			4'h2: pick = 64'(cond_flag_byte);
			4'h3: pick = 64'(intr_blocked_reg);
			4'h4: pick = 64'(trace_req_reg);
			4'h5: pick = 64'(fetch_addr);
			4'h6: pick = 64'(vec_addr_reg);
			4'h7: pick = 64'(mi_target_reg);
			4'h8: pick = 64'(stack_pointer_gpr);
			4'h9: pick = 64'(ctl_rd_data_reg);
			4'hA: pick = 64'(eff_addr_reg);
			4'hC: pick = 64'(mi_addr_reg);
			4'hD: pick = 64'(push_busy);
			default: pick = multiply_accum_reg;
		endcase
	endfunction

	task automatic check(input [63:0] got, input [63:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic go(input [11:0] m);
		stb <= m;
		@(posedge clk);
		stb <= 12'h000;
	endtask

	task automatic look(input [3:0] s, input [63:0] v);
		q.push_back({s, v});
		@(posedge clk);
		obs_en <= 1'b1;
		@(posedge clk);
		obs_en <= 1'b0;
	endtask

	task automatic wr(input [2:0] x, input [1:0] s, input u, input h,
		input [31:0] d);
		@(posedge clk);
		{gpr_wr_idx, gpr_wr_size, gpr_wr_upper, gpr_wr_byte_hi} <= {x, s, u, h};
		gpr_wr_data <= d;
		go(12'h400);
	endtask

	task automatic rd(input [2:0] x, input [1:0] s, input u, input h,
		input [31:0] e);
		@(posedge clk);
		{gpr_rd_idx, gpr_rd_size, gpr_rd_upper, gpr_rd_byte_hi} <= {x, s, u, h};
		look(4'h0, 64'(e));
	endtask

	task automatic ctl(input e, input [2:0] o, input [7:0] d);
		@(posedge clk);
		{ctl_sel_ext, ctl_op, ctl_op_data} <= {e, o, d};
		go(12'h800);
	endtask

	task automatic cop(input [2:0] o, input [7:0] d, input [7:0] e);
		ctl(1'b1, o, d);
		look(4'h3, 64'h1);
		look(4'h3, 64'h0);
		look(4'h1, 64'(e));
	endtask

	// The trace pulse lasts one cycle, so it is looked at right away
	task automatic trc(input e);
		@(posedge clk);
		q.push_back({4'h4, 63'h0, e});
		stb <= 12'h010;
		@(posedge clk);
		stb <= 12'h000;
		obs_en <= 1'b1;
		@(posedge clk);
		obs_en <= 1'b0;
	endtask

	task automatic idle;
		int t;
		@(negedge clk);
		for (t = 0; t < 50 && push_busy !== 1'b0; t++)
			@(negedge clk);
	endtask

	always @(negedge clk)
	begin
		if (obs_en)
		begin
			n = q.pop_front();
			check(pick(n[67:64]), n[63:0]);
		end
		if (push_valid === 1'b1)
			check(64'({push_long, push_addr, push_data}),
				64'(pq.pop_front()));
	end

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial
	begin
		#2_000_000;
		error_cnt++;
		final_report;
	end

	initial
	begin
		{obs_en, gpr_wr_upper, gpr_wr_byte_hi, gpr_rd_upper} = 4'h0;
		{gpr_rd_byte_hi, ctl_sel_ext, stb, gpr_wr_idx, gpr_rd_idx} = '0;
		{addr_idx, ctl_op, gpr_wr_size, gpr_rd_size, intr_ctrl_mode} = '0;
		{gpr_wr_data, vec_rdata, mi_rdata, mac_wr_data, pc_load_data} = '0;
		{vec_num, mi_field, ctl_op_data, flag_wr_data} = 32'h0000_0000;
		reset = 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		look(4'h1, 64'h7F);
		look(4'h2, 64'h80);
		look(4'h5, 64'h0);
		look(4'hB, 64'h0);
		r = 16'hE3F2;
		for (i = 0; i < 8; i++)
		begin
			r = lfsr(r);
			gv[i] = {r, lfsr(r)};
			wr(i[2:0], 2'h2, 1'b0, 1'b0, gv[i]);
		end
		for (i = 0; i < 8; i++)
			rd(i[2:0], 2'h2, 1'b0, 1'b0, gv[i]);
		wr(3'h3, 2'h1, 1'b1, 1'b0, 32'h0000_BEEF);
		wr(3'h3, 2'h0, 1'b0, 1'b1, 32'h0000_005C);
		wr(3'h3, 2'h0, 1'b0, 1'b0, 32'h0000_00A1);
		gv[3] = {16'hBEEF, 8'h5C, 8'hA1};
		rd(3'h3, 2'h1, 1'b1, 1'b0, 32'h0000_BEEF);
		rd(3'h3, 2'h1, 1'b0, 1'b0, 32'h0000_5CA1);
		rd(3'h3, 2'h0, 1'b0, 1'b1, 32'h0000_005C);
		rd(3'h3, 2'h0, 1'b0, 1'b0, 32'h0000_00A1);
		rd(3'h3, 2'h2, 1'b0, 1'b0, gv[3]);
		rd(3'h2, 2'h2, 1'b0, 1'b0, gv[2]);
		@(posedge clk);
		addr_idx <= 3'h3;
		look(4'hA, 64'(gv[3][23:0]));
		look(4'h8, 64'(gv[7]));
		cop(3'h0, 8'h00, 8'h78);
		cop(3'h2, 8'h85, 8'hFD);
		cop(3'h1, 8'h06, 8'h7C);
		cop(3'h3, 8'h83, 8'hFF);
		ctl(1'b1, 3'h4, 8'h00);
		look(4'h3, 64'h0);
		look(4'h9, 64'hFF);
		trc(1'b1);
		cop(3'h0, 8'h07, 8'h7F);
		trc(1'b0);
		ctl(1'b0, 3'h0, 8'h5A);
		look(4'h3, 64'h0);
		look(4'h2, 64'h5A);
		@(posedge clk);
		flag_wr_data <= 8'h21;
		mac_wr_data <= 32'h1357_9BDF;
		go(12'h380);
		look(4'h2, 64'h21);
		look(4'hB, 64'h1357_9BDF_1357_9BDF);
		@(posedge clk);
		pc_load_data <= 24'h12_3457;
		vec_num <= 8'hFF;
		go(12'h002);
		look(4'h5, 64'h12_3456);
		look(4'h6, 64'h3FC);
		go(12'h001);
		look(4'h5, 64'h12_3458);
		@(posedge clk);
		vec_rdata <= 32'hAB65_4321;
		go(12'h004);
		look(4'h5, 64'h65_4320);
		@(posedge clk);
		mi_field <= 8'hFF;
		mi_rdata <= 32'hFFAB_CDEF;
		go(12'h008);
		look(4'h7, 64'hAB_CDEF);
		look(4'h5, 64'hAB_CDEE);
		look(4'hC, 64'hFF);
		wr(3'h7, 2'h2, 1'b0, 1'b0, 32'h0000_1000);
		@(posedge clk);
		pc_load_data <= 24'h00_2468;
		intr_ctrl_mode <= 2'h2;
		go(12'h002);
		pq.push_back({1'b1, 24'h00_0FFC, 32'h2100_2468});
		pq.push_back({1'b0, 24'h00_0FFA, 32'h0000_7F00});
		@(posedge clk);
		go(12'h020);
		look(4'hD, 64'h1);
		idle;
		look(4'h8, 64'hFFA);
		@(posedge clk);
		intr_ctrl_mode <= 2'h0;
		pq.push_back({1'b1, 24'h00_0FF6, 32'h2100_2468});
		go(12'h020);
		idle;
		look(4'h8, 64'hFF6);
		pq.push_back({1'b1, 24'h00_0FF2, 32'h0000_2468});
		@(posedge clk);
		go(12'h040);
		idle;
		look(4'h8, 64'hFF2);
		repeat (4) @(posedge clk);
		check(64'(pq.size()), 64'h0);
		final_report;
	end
endmodule // cpu_register_file_adv_mode_tb

// File: regfile_chk.sv
`timescale 1ns/1ps
module regfile_chk (
	input wire        clk,
	input wire        reset,
	input wire [23:0] fetch_addr,
	input wire [7:0]  extension_control_byte,
	input wire [2:0]  intr_mask_level,
	input wire        ctl_op_en,
	input wire        ctl_sel_ext,
	input wire [2:0]  ctl_op,
	input wire        intr_blocked_reg,
	input wire        instr_done,
	input wire        trace_req_reg,
	input wire [31:0] mi_target_reg,
	input wire [7:0]  vec_num,
	input wire [23:0] vec_addr_reg,
	input wire [7:0]  mi_field,
	input wire [23:0] mi_addr_reg
);
	// Stores never open the interrupt shadow
	wire blk_op = ctl_op_en && ctl_sel_ext && (ctl_op != 3'h4);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_fetch_even: assert property (
		fetch_addr[0] == 1'b0)
		else $error("fetch address odd");
	chk_rsvd_ones: assert property (
		extension_control_byte[6:3] == 4'hF)
		else $error("reserved control bits not one");
	chk_mask_view: assert property (
		intr_mask_level == extension_control_byte[2:0])
		else $error("mask level view differs");
	chk_block_three: assert property (
		blk_op |=> intr_blocked_reg [*3])
		else $error("interrupt shadow too short");
	chk_block_cause: assert property (
		$rose(intr_blocked_reg) |-> $past(blk_op))
		else $error("interrupt shadow without cause");
	chk_trace_fire: assert property (
		instr_done && extension_control_byte[7] |=> trace_req_reg)
		else $error("trace request missing");
	chk_trace_quiet: assert property (
		trace_req_reg |->
		$past(instr_done && extension_control_byte[7]))
		else $error("trace request unexpected");
	chk_mi_top: assert property (
		mi_target_reg[31:24] == 8'h00)
		else $error("indirect target top byte not zero");
	chk_vec_slot: assert property (
		!$past(reset) |->
		vec_addr_reg == {14'h0000, $past(vec_num), 2'h0})
		else $error("vector slot address wrong");
	chk_mi_window: assert property (
		!$past(reset) |-> mi_addr_reg == {16'h0000, $past(mi_field)})
		else $error("indirect operand outside low page");
endmodule // regfile_chk
bind cpu_register_file_adv_mode regfile_chk u_regfile_chk (
	.clk                    (clk),
	.reset                  (reset),
	.fetch_addr             (fetch_addr),
	.extension_control_byte (extension_control_byte),
	.intr_mask_level        (intr_mask_level),
	.ctl_op_en              (ctl_op_en),
	.ctl_sel_ext            (ctl_sel_ext),
	.ctl_op                 (ctl_op),
	.intr_blocked_reg       (intr_blocked_reg),
	.instr_done             (instr_done),
	.trace_req_reg          (trace_req_reg),
	.mi_target_reg          (mi_target_reg),
	.vec_num                (vec_num),
	.vec_addr_reg           (vec_addr_reg),
	.mi_field               (mi_field),
	.mi_addr_reg            (mi_addr_reg)
);

// File: stack_frame_push.v
`timescale 1ns/1ps
`include "cpu_regfile_defs.vh"

module stack_frame_push (
	input  wire        clk,
	input  wire        reset,
	input  wire        exc_start,
	input  wire        call_start,
	input  wire [1:0]  intr_ctrl_mode,
	input  wire [23:0] pc,
	input  wire [7:0]  cond_flag_byte,
	input  wire [7:0]  extension_control_byte,
	input  wire [31:0] sp,
	output wire        busy,
	output reg         push_valid_reg,
	output reg         push_long_reg,
	output reg  [23:0] push_addr_reg,
	output reg  [31:0] push_data_reg,
	output reg         sp_wr_en_reg,
	output reg  [31:0] sp_wr_data_reg
);

	localparam ST_IDLE = 2'b01;
	localparam ST_WORD = 2'b10;

	reg [1:0]  state_reg;
	wire        push_start;
	wire [31:0] sp_long = sp - `PUSH_LONG_STEP;
	wire [31:0] sp_word = sp_wr_data_reg - `PUSH_WORD_STEP;

	assign busy = (state_reg != ST_IDLE) | sp_wr_en_reg;
	// A start during the trailing SP write would push from a stale SP
	assign push_start = (exc_start | call_start) & ~sp_wr_en_reg;

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg      <= ST_IDLE;
			push_valid_reg <= 1'b0;
			push_long_reg  <= 1'b0;
			push_addr_reg  <= `PC_RESET;
			push_data_reg  <= `GPR_RESET;
			sp_wr_en_reg   <= 1'b0;
			sp_wr_data_reg <= `GPR_RESET;
		end
		else
		begin
			case (state_reg)
			ST_IDLE:
			begin
				push_valid_reg <= push_start;
				sp_wr_en_reg   <= push_start;
				if (push_start)
				begin
					// PC longword goes first, flags ride in its top byte on exceptions, zero on calls
					push_long_reg  <= 1'b1;
					push_addr_reg  <= sp_long[23:0];
					sp_wr_data_reg <= sp_long;
					if (exc_start)
						push_data_reg <= {cond_flag_byte, pc};
					else
						push_data_reg <= {`RSVD_BYTE, pc};
					if (exc_start && intr_ctrl_mode != `ICM_MODE0)
						state_reg <= ST_WORD;
				end
			end
			ST_WORD:
			begin
				// Own copy of SP used; the register file lags one edge
				push_valid_reg <= 1'b1;
				push_long_reg  <= 1'b0;
				push_addr_reg  <= sp_word[23:0];
				push_data_reg  <= {`WORD_PAD, extension_control_byte,
					`RSVD_BYTE};
				sp_wr_en_reg   <= 1'b1;
				sp_wr_data_reg <= sp_word;
				state_reg      <= ST_IDLE;
			end
			default:
			begin
				state_reg      <= ST_IDLE;
				push_valid_reg <= 1'b0;
				sp_wr_en_reg   <= 1'b0;
			end
			endcase
		end
	end

endmodule // stack_frame_push
